// >>> logic/smpg_pkg.sv
package smpg_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int SPD_W  = 21;
  localparam int ACC_W  = 16;
  localparam int JRK_W  = 16;
  localparam int TGT_W  = 24;
  localparam int POS_W  = 32;
  localparam int REM_W  = 33;
  localparam int FX_W   = 48;
  localparam int PRD_W  = 96;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************
  // limits
  // ****************************************
  localparam logic [SPD_W-1:0]        START_MIN = 21'h000001;
  localparam logic [SPD_W-1:0]        START_MAX = 21'h1e847f;
  localparam logic [JRK_W-1:0]        JRK_MAX   = 16'h1388;
  localparam logic signed [TGT_W-1:0] TGT_MAX   = 24'sh7fffff;

  // ****************************************
  // scaling: speeds are held in units of 1/FX_SCALE step/s, so one
  // shape unit times the acceleration is exactly the per-tick jerk
  // ****************************************
  localparam int JRK_DIV  = 100;
  localparam int MS_PER_S = 1000;
  localparam int FX_SCALE = JRK_DIV * MS_PER_S;
  localparam int DEC_K    = 2 * MS_PER_S * FX_SCALE;

  // ****************************************
  // timing
  // ****************************************
  localparam int                CLK_NS   = 10;
  localparam int                TICK_NS  = 1000000;
  localparam int                TICK_CYC = TICK_NS / CLK_NS;
  localparam longint            CLK_HZ   = 1000000000 / CLK_NS;
  localparam logic [FX_W-1:0]   STEP_THR = FX_W'(CLK_HZ * FX_SCALE);

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_START  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TARGET = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SPEED  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ACCEL  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DECEL  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_JERK   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PRESET = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] REG_POS    = 8'h24;
  localparam logic [ADDR_W-1:0] REG_REMAIN = 8'h28;
  localparam logic [SPD_W-1:0]  START_RST  = 21'h000001;

  // ****************************************
  // control and status fields
  // ****************************************
  localparam int CTL_GO    = 0;
  localparam int CTL_ABS   = 1;
  localparam int STS_BUSY  = 0;
  localparam int STS_ERR   = 1;
  localparam int STS_HOME  = 2;
  localparam int STS_DIR   = 3;
  localparam int STS_CFG   = 4;
  localparam int STS_CODE  = 8;
  localparam int STS_PHASE = 12;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {ERR_NONE, ERR_SPEED, ERR_ACCEL, ERR_JERK, ERR_TARGET, ERR_HOME} smpg_err_t;
  typedef enum logic [2:0] {PH_IDLE, PH_CHECK, PH_ACCEL, PH_CRUISE, PH_DECEL} smpg_phase_t;

  typedef struct packed {
    logic signed [TGT_W-1:0] target;
    logic [SPD_W-1:0]        speed;
    logic [ACC_W-1:0]        accel;
    logic [ACC_W-1:0]        decel;
    logic [JRK_W-1:0]        jerk;
    logic                    absolute;
  } smpg_move_t;

  localparam smpg_move_t MOVE_RST = '0;

endpackage

// >>> logic/smpg_step_gen.sv
`timescale 1ns/10ps
module smpg_step_gen
  import smpg_pkg::*;
#(
  parameter logic [FX_W-1:0] THR = STEP_THR
)
(
  // clock and reset
  input  logic            clk_sys,
  input  logic            rst,
  // rate
  input  logic            run,
  input  logic [FX_W-1:0] speed_fx,
  // step out
  output logic            step
);

  logic [FX_W-1:0] phase_acc;
  logic [FX_W-1:0] next_acc;

  if (THR == '0)
  begin : g_bad_thr
    $error("step threshold must be non-zero");
  end

  assign next_acc = phase_acc + speed_fx;

  // ****************************************
  // rate accumulator, one step per threshold crossing
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst || !run)
    begin
      phase_acc <= '0;
      step      <= 1'b0;
    end
    else if (next_acc >= THR)
    begin
      phase_acc <= next_acc - THR;
      step      <= 1'b1;
    end
    else
    begin
      phase_acc <= next_acc;
      step      <= 1'b0;
    end
  end

endmodule

// >>> logic/smpg_top.sv
// Function
// - starting speed is configured, accepted only from 1 to 1,999,999 steps/s
// - relative offset within +/-8,388,607; positive is clockwise, negative counter-clockwise
// - reported position may grow past +/-8,388,607 through chained moves
// - absolute target within +/-8,388,607; direction from target versus position
// - absolute moves only after home has been set
// - three ramp shapes chosen by the shape parameter of the move
// - shape zero ramps at constant programmed acceleration
// - shape 1 to 5,000 varies acceleration, giving S-curves
// - shape held in 16 bits; jerk is shape/100 times acceleration
// - trapezoidal S-curve: rise to acceleration, hold, fall to zero at speed
// - triangular S-curve: start falling before full acceleration is reached
// - move starts by jumping to starting speed, then accelerates
// - cruise at programmed speed until remaining equals stopping distance
// - decelerate at own value; reach starting speed at target, pulses stop
// - trapezoid with cruise when ramp steps are fewer than move steps
// - triangle, never reaching speed, when ramps exceed move length
// - acceleration and deceleration are in steps/s per millisecond
// - whole move checked before any step, else an error, no motion
// - positive moves count position up, negative ones down
`timescale 1ns/10ps
module smpg_top
  import smpg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // clock and reset
  input  logic              clk_sys,
  input  logic              rst,
  // register port
  input  logic [ADDR_W-1:0] addr,
  input  logic [DATA_W-1:0] wdata,
  input  logic              wr,
  input  logic              rd,
  output logic [DATA_W-1:0] rdata,
  // motor side
  output logic              step_pulse,
  output logic              step_dir,
  output logic              moving
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // ****************************************
  // declarations
  // ****************************************
  logic [SPD_W-1:0]        start_speed;
  logic                    cfg_err;
  smpg_move_t              shadow;
  smpg_move_t              mv;
  logic signed [POS_W-1:0] position;
  logic                    home_valid;
  logic                    err_flag;
  smpg_err_t               err_code;
  smpg_err_t               chk_err;
  smpg_phase_t             phase;
  logic [REM_W-1:0]        remaining;
  logic [REM_W-1:0]        mag;
  logic signed [REM_W:0]   delta;
  logic                    dir;
  logic                    running;
  logic                    go_req;
  logic                    tick;
  logic [31:0]             tick_cnt;
  logic                    step_q;
  logic                    shaped;
  logic                    decel_now;
  logic [FX_W-1:0]         v_fx;
  logic [FX_W-1:0]         a_fx;
  logic [FX_W-1:0]         vs_fx;
  logic [FX_W-1:0]         vp_fx;
  logic [FX_W-1:0]         lim_a;
  logic [FX_W-1:0]         lim_d;
  logic [FX_W-1:0]         dj_a;
  logic [FX_W-1:0]         dj_d;
  logic [FX_W-1:0]         dec_eff;
  logic [FX_W-1:0]         next_acc_up;
  logic [FX_W-1:0]         next_acc_dn;
  // stop products carry the tick length as an extra factor
  localparam int STP_W = PRD_W + 32;
  logic [STP_W-1:0]        stop_need;
  logic [STP_W-1:0]        stop_have;
  logic [DATA_W-1:0]       rd_mux;
  logic [DATA_W-1:0]       status;

  // ****************************************
  // ramp shaping
  // ****************************************
  // returns the acceleration for the next tick; with shaping off it is
  // the full limit at once, otherwise it grows by dj until the limit and
  // turns down once the speed still to gain fits the shrinking ramp
  function automatic logic [FX_W-1:0] ramp_acc(
    input logic [FX_W-1:0] cur,
    input logic [FX_W-1:0] lim,
    input logic [FX_W-1:0] dj,
    input logic [FX_W-1:0] gap,
    input logic            on
  );
    logic [PRD_W-1:0] need;
    logic [PRD_W-1:0] have;
    need = (PRD_W'(dj) * PRD_W'(gap)) << 1;
    have = PRD_W'(cur) * (PRD_W'(cur) + PRD_W'(dj));
    if (!on)
      ramp_acc = lim;
    else if (need <= have)
      // floor at dj so the ramp never stalls short of its end speed
      ramp_acc = (cur > (dj << 1)) ? cur - dj : dj;
    else
      ramp_acc = (cur + dj > lim) ? lim : cur + dj;
  endfunction

  // ****************************************
  // derived values
  // ****************************************
  assign running = (phase == PH_ACCEL) || (phase == PH_CRUISE) || (phase == PH_DECEL);
  assign go_req  = wr && (addr == REG_CTRL) && wdata[CTL_GO];
  assign shaped  = (mv.jerk != '0);

  // acceleration in steps/s per ms scales straight into the speed unit
  assign vs_fx = FX_W'(start_speed) * FX_W'(FX_SCALE);
  assign vp_fx = FX_W'(mv.speed) * FX_W'(FX_SCALE);
  assign lim_a = FX_W'(mv.accel) * FX_W'(FX_SCALE);
  assign lim_d = FX_W'(mv.decel) * FX_W'(FX_SCALE);
  // shape times acceleration is the per-tick jerk in this unit
  assign dj_a  = FX_W'(mv.jerk) * FX_W'(mv.accel);
  assign dj_d  = FX_W'(mv.jerk) * FX_W'(mv.decel);

  // an S-curve stop averages about half the peak deceleration, so the
  // stopping distance is taken at half rate; this errs early once the ramp reaches full rate, late when it stays short of it
  assign dec_eff = shaped ? (lim_d >> 1) : lim_d;

  // remaining steps against the distance to fall back to starting speed
  // scaled by the tick length, so a shortened tick still lands on target
  assign stop_need = STP_W'(remaining) * STP_W'(dec_eff) * STP_W'(DEC_K) * STP_W'(TICK_CYC);
  assign stop_have = (STP_W'(v_fx) * STP_W'(v_fx) - STP_W'(vs_fx) * STP_W'(vs_fx)) * STP_W'(TICK_CYCLES);
  assign decel_now = (stop_need <= stop_have);

  always_comb
  begin
    next_acc_up = ramp_acc(a_fx, lim_a, dj_a, vp_fx - v_fx, shaped);
    next_acc_dn = ramp_acc(a_fx, lim_d, dj_d, v_fx - vs_fx, shaped);
  end

  // ****************************************
  // move check
  // ****************************************
  always_comb
  begin
    if (mv.absolute)
      delta = (REM_W+1)'(mv.target) - (REM_W+1)'(position);
    else
      delta = (REM_W+1)'(mv.target);
    mag = delta[REM_W] ? REM_W'(-delta) : REM_W'(delta);
  end

  always_comb
  begin
    if (mv.speed < start_speed || mv.speed > START_MAX)
      chk_err = ERR_SPEED;
    else if (mv.accel == '0 || mv.decel == '0)
      chk_err = ERR_ACCEL;
    else if (mv.jerk > JRK_MAX)
      chk_err = ERR_JERK;
    else if (mv.target < -TGT_MAX)
      chk_err = ERR_TARGET;
    else if (mv.absolute && !home_valid)
      chk_err = ERR_HOME;
    else
      chk_err = ERR_NONE;
  end

  // ****************************************
  // millisecond tick
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (tick_cnt == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick     <= 1'b0;
    end
  end

  // ****************************************
  // configuration and move parameters
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      start_speed <= START_RST;
      cfg_err     <= 1'b0;
      shadow      <= MOVE_RST;
    end
    else if (wr)
    begin
      case (addr)
        REG_START:
        begin
          // configuration only: a change mid-move would break the stop math
          if (phase == PH_IDLE && wdata[SPD_W-1:0] >= START_MIN && wdata[SPD_W-1:0] <= START_MAX
              && wdata[DATA_W-1:SPD_W] == '0)
          begin
            start_speed <= wdata[SPD_W-1:0];
            cfg_err     <= 1'b0;
          end
          else
            cfg_err <= 1'b1;
        end
        REG_TARGET: shadow.target <= wdata[TGT_W-1:0];
        REG_SPEED:  shadow.speed  <= wdata[SPD_W-1:0];
        REG_ACCEL:  shadow.accel  <= wdata[ACC_W-1:0];
        REG_DECEL:  shadow.decel  <= wdata[ACC_W-1:0];
        REG_JERK:   shadow.jerk   <= wdata[JRK_W-1:0];
        default:    shadow        <= shadow;
      endcase
    end
  end

  // ****************************************
  // position and home
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      position   <= '0;
      home_valid <= 1'b0;
    end
    else if (wr && addr == REG_PRESET && phase == PH_IDLE)
    begin
      position   <= wdata;
      home_valid <= 1'b1;
    end
    else if (running && step_q)
    begin
      // full 32-bit count, so chained relative moves run past the target range
      if (dir)
        position <= position + 32'sh00000001;
      else
        position <= position - 32'sh00000001;
    end
  end

  // ****************************************
  // profile sequencer
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phase     <= PH_IDLE;
      mv        <= MOVE_RST;
      remaining <= '0;
      dir       <= 1'b1;
      v_fx      <= '0;
      a_fx      <= '0;
      err_flag  <= 1'b0;
      err_code  <= ERR_NONE;
    end
    else
    begin
      case (phase)
        PH_IDLE:
        begin
          // a move command while busy is ignored
          if (go_req)
          begin
            mv          <= shadow;
            mv.absolute <= wdata[CTL_ABS];
            err_flag    <= 1'b0;
            err_code    <= ERR_NONE;
            phase       <= PH_CHECK;
          end
        end
        PH_CHECK:
        begin
          if (chk_err != ERR_NONE)
          begin
            err_flag <= 1'b1;
            err_code <= chk_err;
            phase    <= PH_IDLE;
          end
          else if (mag == '0)
            phase <= PH_IDLE;
          else
          begin
            remaining <= mag;
            dir       <= ~delta[REM_W];
            v_fx      <= vs_fx;
            a_fx      <= '0;
            phase     <= PH_ACCEL;
          end
        end
        default:
        begin
          if (step_q && remaining == REM_W'(1))
          begin
            // last step out: pulses cease at the target
            remaining <= '0;
            v_fx      <= '0;
            a_fx      <= '0;
            phase     <= PH_IDLE;
          end
          else
          begin
            if (step_q)
              remaining <= remaining - REM_W'(1);
            if (tick)
            begin
              case (phase)
                PH_ACCEL:
                begin
                  if (decel_now)
                  begin
                    a_fx  <= '0;
                    phase <= PH_DECEL;
                  end
                  else if (v_fx + next_acc_up >= vp_fx)
                  begin
                    v_fx  <= vp_fx;
                    a_fx  <= '0;
                    phase <= PH_CRUISE;
                  end
                  else
                  begin
                    v_fx <= v_fx + next_acc_up;
                    a_fx <= next_acc_up;
                  end
                end
                PH_CRUISE:
                begin
                  if (decel_now)
                    phase <= PH_DECEL;
                end
                PH_DECEL:
                begin
                  // clamp at starting speed so the last steps arrive there
                  if (v_fx - vs_fx > next_acc_dn)
                    v_fx <= v_fx - next_acc_dn;
                  else
                    v_fx <= vs_fx;
                  a_fx <= next_acc_dn;
                end
                default:
                  phase <= PH_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // step pulse generator
  // ****************************************
  smpg_step_gen #(
    .THR      (STEP_THR)
  ) u_step_gen (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (running),
    .speed_fx (v_fx),
    .step     (step_q)
  );

  assign step_pulse = step_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      step_dir <= 1'b1;
      moving   <= 1'b0;
    end
    else
    begin
      step_dir <= dir;
      moving   <= (phase != PH_IDLE);
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always_comb
  begin
    status                          = '0;
    status[STS_BUSY]                = (phase != PH_IDLE);
    status[STS_ERR]                 = err_flag;
    status[STS_HOME]                = home_valid;
    status[STS_DIR]                 = dir;
    status[STS_CFG]                 = cfg_err;
    status[STS_CODE+2:STS_CODE]     = err_code;
    status[STS_PHASE+2:STS_PHASE]   = phase;
  end

  always_comb
  begin
    case (addr)
      REG_START:  rd_mux = DATA_W'(start_speed);
      REG_TARGET: rd_mux = DATA_W'(shadow.target);
      REG_SPEED:  rd_mux = DATA_W'(shadow.speed);
      REG_ACCEL:  rd_mux = DATA_W'(shadow.accel);
      REG_DECEL:  rd_mux = DATA_W'(shadow.decel);
      REG_JERK:   rd_mux = DATA_W'(shadow.jerk);
      REG_STATUS: rd_mux = status;
      REG_POS:    rd_mux = position;
      REG_REMAIN: rd_mux = remaining[DATA_W-1:0];
      default:    rd_mux = '0;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata <= '0;
    else if (rd)
      rdata <= rd_mux;
    else
      rdata <= '0;
  end

endmodule

// >>> tb/smpg_chk_props.sv
`timescale 1ns/10ps
module smpg_chk
  import smpg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // clock and reset
  input logic              clk_sys,
  input logic              rst,
  // register port
  input logic [ADDR_W-1:0] addr,
  input logic [DATA_W-1:0] wdata,
  input logic              wr,
  input logic              rd,
  input logic [DATA_W-1:0] rdata,
  // motor side
  input logic              step_pulse,
  input logic              step_dir,
  input logic              moving
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  rdata_quiet_a: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside its slot");
  step_single_a: assert property (step_pulse |=> !step_pulse [*8])
    else $error("steps faster than top rate");
  step_idle_a: assert property (!moving |-> !step_pulse)
    else $error("step while not moving");
  go_start_a: assert property (wr && addr == REG_CTRL && wdata[CTL_GO] && !moving |-> ##2 moving)
    else $error("go did not start a move");
  first_step_a: assert property ($rose(moving) |-> !step_pulse [*3])
    else $error("step before profile checked");
  go_cause_a: assert property ($rose(moving) |-> $past(wr && addr == REG_CTRL && wdata[CTL_GO], 2))
    else $error("move began without a command");
  dir_steady_a: assert property (step_pulse |-> $stable(step_dir) && $past(moving))
    else $error("direction changed at a step");
  stop_quiet_a: assert property ($fell(moving) |-> !step_pulse [*8])
    else $error("step after move end");
endmodule

bind smpg_top smpg_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .step_pulse, .step_dir, .moving);

// >>> tb/smpg_host.sv
`timescale 1ns/10ps
module smpg_host
  import smpg_pkg::*;
(
  // clock
  input  logic              clk_sys,
  // register port
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata,
  output logic              wr,
  output logic              rd,
  input  logic [DATA_W-1:0] rdata
);
  // idle cycles before each request, so the host can be prompt or slow
  int gap = 0;

  initial
  begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  // the leading edge keeps two strobes from being assigned in one step
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    repeat (gap + 1) @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic get(input logic [7:0] a, output logic [31:0] d);
    repeat (gap + 1) @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask

  // speed and ramps go with every move, never left from a prior one
  task automatic move(input logic [23:0] t, input logic [20:0] v, input logic [15:0] ac,
                      input logic [15:0] dc, input logic [15:0] j, input logic ab);
    put(REG_TARGET, 32'(t));
    put(REG_SPEED, 32'(v));
    put(REG_ACCEL, 32'(ac));
    put(REG_DECEL, 32'(dc));
    put(REG_JERK, 32'(j));
    put(REG_CTRL, {30'h0, ab, 1'b1});
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
  import smpg_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        step_pulse;
  logic        step_dir;
  logic        moving;
  logic [31:0] sts;
  logic [31:0] val;
  logic [7:0]  seen;
  int          failures = 0;
  int          samples_checked = 0;
  int          steps = 0;

  smpg_host host_u (.clk_sys, .addr, .wdata, .wr, .rd, .rdata);
  // short tick keeps ramps to a few thousand cycles
  smpg_top #(.TICK_CYCLES(100)) dut_u (.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .step_pulse,
    .step_dir, .moving);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (step_pulse === 1'b1)
      steps <= steps + 1;

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic run(input logic [23:0] t, input logic [20:0] v, input logic [15:0] ac,
                     input logic [15:0] j, input logic ab);
    int i;
    steps = 0;
    seen  = '0;
    host_u.move(t, v, ac, 16'h7530, j, ab);
    for (i = 0; i < 12000; i++)
    begin
      host_u.get(REG_STATUS, sts);
      seen[sts[14:12]] = 1'b1;
      if (sts[STS_BUSY] === 1'b0)
        break;
    end
    @(posedge clk_sys);
    if (i == 12000)
    begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic bad(input logic [23:0] t, input logic [20:0] v, input logic [15:0] ac,
                     input logic [15:0] j, input logic ab, input logic [2:0] c);
    run(t, v, ac, j, ab);
    chk("err_code", 32'({1'b1, c}), 32'({sts[STS_ERR], sts[10:8]}));
    chk("err_steps", '0, 32'(steps));
  endtask

  task automatic mv(input logic [23:0] t, input logic [15:0] j, input logic ab, input int n,
                    input logic [31:0] p, input logic dd, input logic cr);
    run(t, 21'h1cfde0, 16'hea60, j, ab);
    chk("steps", 32'(n), 32'(steps));
    host_u.get(REG_POS, val);
    chk("pos", p, val);
    chk("dir", 32'(dd), 32'(step_dir));
    chk("cruise", 32'(cr), 32'(seen[PH_CRUISE]));
    chk("moving", '0, 32'(moving));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    host_u.get(REG_START, val);
    chk("start", 32'h1, val);
    host_u.get(REG_POS, val);
    chk("pos", '0, val);
    host_u.get(REG_STATUS, sts);
    chk("idle", '0, 32'(sts[2:0]));
    host_u.get(8'h40, val);
    chk("unmapped", '0, val);
  endtask

  task automatic t_start;
    logic [31:0] v [3] = '{32'h0, 32'h1e8480, 32'h1e847f};
    host_u.gap = 3;
    foreach (v[k])
    begin
      host_u.put(REG_START, v[k]);
      host_u.get(REG_STATUS, sts);
      chk("cfg_err", 32'(k < 2), 32'(sts[STS_CFG]));
      host_u.get(REG_START, val);
      chk("start", k < 2 ? 32'h1 : v[k], val);
    end
    host_u.gap = 0;
    host_u.put(REG_START, 32'hf4240);
  endtask

  task automatic t_err;
    bad(24'h10, 21'h0f423f, 16'hea60, 16'h0, 1'b0, 3'h1);
    bad(24'h10, 21'h1e8480, 16'hea60, 16'h0, 1'b0, 3'h1);
    bad(24'h10, 21'h1cfde0, 16'h0, 16'h0, 1'b0, 3'h2);
    bad(24'h10, 21'h1cfde0, 16'hea60, 16'h1389, 1'b0, 3'h3);
    bad(24'h800000, 21'h1cfde0, 16'hea60, 16'h0, 1'b0, 3'h4);
    bad(24'h10, 21'h1cfde0, 16'hea60, 16'h0, 1'b1, 3'h5);
  endtask

  task automatic t_rel;
    mv(24'h64, 16'h0, 1'b0, 100, 32'h64, 1'b1, 1'b1);
    mv(24'hfffff6, 16'h0, 1'b0, 10, 32'h5a, 1'b0, 1'b0);
    mv(24'h12c, 16'h1388, 1'b0, 300, 32'h186, 1'b1, 1'b1);
    mv(24'hffffd8, 16'h1, 1'b0, 40, 32'h15e, 1'b0, 1'b0);
  endtask

  task automatic t_abs;
    host_u.put(REG_PRESET, 32'h7ffff8);
    host_u.get(REG_STATUS, sts);
    chk("home", 32'h1, 32'(sts[STS_HOME]));
    mv(24'h14, 16'h0, 1'b0, 20, 32'h80000c, 1'b1, 1'b0);
    mv(24'h7fff94, 16'h0, 1'b1, 120, 32'h7fff94, 1'b0, 1'b1);
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_start();
    t_err();
    t_rel();
    t_abs();
    end_of_test();
  end
endmodule
